// >>> design/sms_master.sv
/*
 * Serial master serving several slaves, one slave packet per execution step.
 * Assumes step pulses come from logic on clk; the slave data input is asynchronous.
 */
// What this block does
// - Words of 1 to 16 bits are shifted out and in as bit streams.
// - One master, one or more slaves; only the master starts transfers.
// - The master makes the shift clock, the configured pulse count per step.
// - Chip-selects are active low; low selects that slave.
// - Data is driven on one shift-clock edge and sampled on the opposite one.
// - With phase 1, data is presented half a clock before the transition.
// - One slave per step, slaves visited in order, cycling forever.
// - In a step the current slave is selected and its packet exchanged.
// - Transmit words arrive as one stream concatenated in slave order.
// - Received words form one vector concatenated in slave order.
// - Valid goes to 1 once data has been sent to all slaves.
// - Overrun goes to 1 when a step starts before the last transfer ended.
// - Polarity sets the idle level of the shift clock.
// - Words per step are configured separately for each slave.
module sms_master #(
    parameter int NS       = sms_pkg::SMS_SLAVES,
    parameter int WPS_W    = sms_pkg::SMS_WPS_W,
    parameter int FIFO_D   = sms_pkg::SMS_FIFO_DEPTH,
    parameter int RX_DEPTH = sms_pkg::SMS_RX_DEPTH
) (
    input  wire logic                                 clk,
    input  wire logic                                 reset,
    input  wire logic                                 step,
    input  wire logic                                 cpol,
    input  wire logic                                 cpha,
    input  wire logic [sms_pkg::SMS_BITS_W-1:0]       bits_per_word,
    input  wire logic [sms_pkg::SMS_DIV_W-1:0]        clk_half,
    input  wire logic [NS-1:0][WPS_W-1:0]             words_per_slave,
    input  wire logic                                 tx_valid,
    input  wire logic [sms_pkg::SMS_WORD_MAX-1:0]     tx_data,
    output logic                                      tx_ready,
    input  wire logic [$clog2(RX_DEPTH)-1:0]          rx_rd_addr,
    output logic      [sms_pkg::SMS_WORD_MAX-1:0]     rx_rd_data,
    output logic                                      shift_clock,
    output logic                                      serial_out_to_slave,
    input  wire logic                                 serial_in_from_slave,
    output logic      [NS-1:0]                        slave_select_n,
    output logic                                      busy,
    output logic                                      valid,
    output logic                                      overrun
);
    localparam int WM = sms_pkg::SMS_WORD_MAX;
    localparam int CW = (NS > 1) ? $clog2(NS) : 1;
    localparam int AW = $clog2(RX_DEPTH);
    localparam int EW = sms_pkg::SMS_EDGE_W;
    localparam int DW = sms_pkg::SMS_DIV_W;

    typedef struct packed {
        logic                miso_meta;
        logic                miso;
        sms_pkg::sms_state_t st;
        logic [CW-1:0]       cur;
        logic [WPS_W-1:0]    words_left;
        logic [WM-1:0]       tx_sr;
        logic [WM-1:0]       rx_sr;
        logic [EW-1:0]       edges;
        logic [DW-1:0]       div;
        logic                sclk;
        logic                mosi;
        logic [NS-1:0]       cs_n;
        logic                valid;
        logic                overrun;
        logic                busy;
        logic [AW-1:0]       rx_ptr;
        logic                wr_en;
        logic [AW+WM-1:0]    wr_word;
    } sms_master_state_t;

    sms_master_state_t s;
    sms_master_state_t next_s;

    sms_word_if #(.W(WM))      tx_if ();
    sms_word_if #(.W(AW + WM)) rx_if ();

    logic [4:0]      bits;
    logic [DW-1:0]   half_m1;
    logic            div_hit;
    logic            sample_edge;
    logic [WM-1:0]   rx_new;
    logic [WM-1:0]   tx_aligned;
    logic [EW-1:0]   edges_total;

    sms_fifo #(
        .W     (WM),
        .DEPTH (FIFO_D)
    ) u_fifo (
        .clk      (clk),
        .reset    (reset),
        .in_valid (tx_valid),
        .in_data  (tx_data),
        .in_ready (tx_ready),
        .out      (tx_if.src)
    );

    sms_rx_mem #(
        .W     (WM),
        .DEPTH (RX_DEPTH)
    ) u_rx_mem (
        .clk     (clk),
        .reset   (reset),
        .wr      (rx_if.snk),
        .rd_addr (rx_rd_addr),
        .rd_data (rx_rd_data)
    );

    // Out-of-range word lengths are clamped so a bad setting cannot hang the shifter.
    always_comb begin
        if (bits_per_word < sms_pkg::SMS_BITS_MIN) begin
            bits = sms_pkg::SMS_BITS_MIN;
        end else if (bits_per_word > sms_pkg::SMS_BITS_MAX) begin
            bits = sms_pkg::SMS_BITS_MAX;
        end else begin
            bits = bits_per_word;
        end
    end

    assign half_m1     = (clk_half == '0) ? '0 : clk_half - 1'b1;
    assign div_hit     = (s.div == half_m1);
    assign edges_total = EW'({bits, 1'b0});
    assign tx_aligned  = tx_if.data << (5'(WM) - bits);
    assign sample_edge = (s.st == sms_pkg::SMS_SHIFT) && div_hit && (s.edges[0] == !cpha);
    assign rx_new      = {s.rx_sr[WM-2:0], s.miso};

    always_comb begin
        next_s           = s;
        next_s.miso_meta = serial_in_from_slave;
        next_s.miso      = s.miso_meta;
        next_s.wr_en     = 1'b0;
        tx_if.ready      = 1'b0;
        case (s.st)
            sms_pkg::SMS_IDLE: begin
                next_s.sclk = cpol;
                next_s.div  = '0;
                if (step) begin
                    next_s.overrun    = 1'b0;
                    next_s.busy       = 1'b1;
                    next_s.cs_n       = ~(NS'(1) << s.cur);
                    next_s.words_left = words_per_slave[s.cur];
                    if (s.cur == '0) begin
                        next_s.rx_ptr = '0;
                    end
                    next_s.st = (words_per_slave[s.cur] == '0) ? sms_pkg::SMS_END : sms_pkg::SMS_LOAD;
                end
            end
            sms_pkg::SMS_LOAD: begin
                // Waiting here when the FIFO is dry stalls the link rather than sending junk.
                tx_if.ready = 1'b1;
                if (tx_if.valid) begin
                    next_s.tx_sr      = tx_aligned;
                    next_s.mosi       = tx_aligned[WM-1];
                    next_s.rx_sr      = sms_pkg::SMS_SR_RESET;
                    next_s.edges      = '0;
                    next_s.div        = '0;
                    next_s.words_left = s.words_left - 1'b1;
                    next_s.st         = sms_pkg::SMS_SHIFT;
                end
            end
            sms_pkg::SMS_SHIFT: begin
                next_s.div = div_hit ? '0 : s.div + 1'b1;
                if (div_hit) begin
                    next_s.sclk  = !s.sclk;
                    next_s.edges = s.edges + 1'b1;
                    if (sample_edge) begin
                        next_s.rx_sr = rx_new;
                    end else if (cpha || (s.edges != '0)) begin
                        next_s.tx_sr = s.tx_sr << 1;
                        next_s.mosi  = s.tx_sr[WM-2];
                    end
                    if (s.edges + 1'b1 == edges_total) begin
                        next_s.wr_en   = 1'b1;
                        next_s.wr_word = {s.rx_ptr, (sample_edge ? rx_new : s.rx_sr)};
                        next_s.rx_ptr  = s.rx_ptr + 1'b1;
                        next_s.st      = (s.words_left == '0) ? sms_pkg::SMS_END : sms_pkg::SMS_LOAD;
                    end
                end
            end
            sms_pkg::SMS_END: begin
                next_s.div = div_hit ? '0 : s.div + 1'b1;
                if (div_hit) begin
                    next_s.cs_n = '1;
                    next_s.busy = 1'b0;
                    next_s.st   = sms_pkg::SMS_IDLE;
                    if (s.cur == CW'(NS - 1)) begin
                        next_s.cur   = '0;
                        next_s.valid = 1'b1;
                    end else begin
                        next_s.cur = s.cur + 1'b1;
                    end
                end
            end
            default: begin
                next_s.st = sms_pkg::SMS_IDLE;
            end
        endcase
        // A step arriving mid-transfer is dropped and flagged.
        if (step && (s.st != sms_pkg::SMS_IDLE)) begin
            next_s.overrun = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s      <= '0;
            s.cs_n <= '1;
            s.st   <= sms_pkg::SMS_IDLE;
        end else begin
            s <= next_s;
        end
    end

    assign rx_if.valid         = s.wr_en;
    assign rx_if.data          = s.wr_word;
    assign shift_clock         = s.sclk;
    assign serial_out_to_slave = s.mosi;
    assign slave_select_n      = s.cs_n;
    assign busy                = s.busy;
    assign valid               = s.valid;
    assign overrun             = s.overrun;

    sequence s_clean_start;
        step && (s.st == sms_pkg::SMS_IDLE) && !reset;
    endsequence

    sequence s_packet_end;
        (s.st == sms_pkg::SMS_END) && div_hit;
    endsequence

    property p_one_select;
        @(posedge clk) disable iff (reset)
        $countones(~slave_select_n) <= 1;
    endproperty
    a_one_select: assert property (p_one_select) else $error("More than one slave selected.");

    property p_idle_level;
        @(posedge clk) disable iff (reset)
        (s.st == sms_pkg::SMS_IDLE) ##1 (s.st == sms_pkg::SMS_IDLE) |-> (shift_clock == $past(cpol));
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("Shift clock not at idle level.");

    property p_overrun_set;
        @(posedge clk) disable iff (reset)
        (step && busy) |=> overrun;
    endproperty
    a_overrun_set: assert property (p_overrun_set) else $error("Overrun missed on early step.");

    property p_select_on_step;
        @(posedge clk) disable iff (reset)
        s_clean_start |=> (!overrun && !slave_select_n[$past(s.cur)] && busy);
    endproperty
    a_select_on_step: assert property (p_select_on_step) else $error("Step did not select slave.");

    property p_release;
        @(posedge clk) disable iff (reset)
        s_packet_end |=> (&slave_select_n) && !busy;
    endproperty
    a_release: assert property (p_release) else $error("Select not released at end.");

    property p_rotate;
        @(posedge clk) disable iff (reset)
        s_packet_end |=> (s.cur == (($past(s.cur) == CW'(NS - 1)) ? '0 : $past(s.cur) + 1'b1));
    endproperty
    a_rotate: assert property (p_rotate) else $error("Slave order broken.");

    property p_valid_rise;
        @(posedge clk) disable iff (reset)
        $rose(valid) |-> ($past(s.st) == sms_pkg::SMS_END) && ($past(s.cur) == CW'(NS - 1));
    endproperty
    a_valid_rise: assert property (p_valid_rise) else $error("Valid rose before last slave.");

    property p_sample_on_edge;
        @(posedge clk) disable iff (reset)
        sample_edge |=> (shift_clock != $past(shift_clock));
    endproperty
    a_sample_on_edge: assert property (p_sample_on_edge) else $error("Sample not on clock edge.");

    property p_edge_bound;
        @(posedge clk) disable iff (reset)
        (s.st == sms_pkg::SMS_SHIFT) |-> (s.edges < edges_total);
    endproperty
    a_edge_bound: assert property (p_edge_bound) else $error("Too many clock edges per word.");

    sequence s_word_done;
        (s.st == sms_pkg::SMS_SHIFT) && div_hit && (s.edges + 1'b1 == edges_total);
    endsequence

    sequence s_word_taken;
        (s.st == sms_pkg::SMS_LOAD) && tx_if.valid;
    endsequence

    property p_busy_match;
        @(posedge clk) disable iff (reset)
        busy == (s.st != sms_pkg::SMS_IDLE);
    endproperty
    a_busy_match: assert property (p_busy_match) else $error("Busy does not follow the transfer.");

    property p_idle_deselect;
        @(posedge clk) disable iff (reset)
        (s.st == sms_pkg::SMS_IDLE) |-> (&slave_select_n);
    endproperty
    a_idle_deselect: assert property (p_idle_deselect) else $error("Slave selected while idle.");

    property p_word_store;
        @(posedge clk) disable iff (reset)
        s_word_done |=> rx_if.valid && (rx_if.data[AW+WM-1:WM] == $past(s.rx_ptr));
    endproperty
    a_word_store: assert property (p_word_store) else $error("Received word not stored in order.");

    property p_word_pop;
        @(posedge clk) disable iff (reset)
        s_word_taken |=> (s.st == sms_pkg::SMS_SHIFT) && (serial_out_to_slave == $past(tx_aligned[WM-1]));
    endproperty
    a_word_pop: assert property (p_word_pop) else $error("Loaded word not presented.");

    // The slave samples on this edge, so the data line must not move with it.
    property p_hold_on_sample;
        @(posedge clk) disable iff (reset)
        sample_edge |=> $stable(serial_out_to_slave);
    endproperty
    a_hold_on_sample: assert property (p_hold_on_sample) else $error("Data moved on sample edge.");

    property p_clock_still;
        @(posedge clk) disable iff (reset)
        ((s.st == sms_pkg::SMS_LOAD) || (s.st == sms_pkg::SMS_END)) |=> $stable(shift_clock);
    endproperty
    a_clock_still: assert property (p_clock_still) else $error("Shift clock moved between words.");

    property p_valid_sticky;
        @(posedge clk) disable iff (reset)
        valid |=> valid;
    endproperty
    a_valid_sticky: assert property (p_valid_sticky) else $error("Valid dropped after a full round.");

    property p_words_loaded;
        @(posedge clk) disable iff (reset)
        s_clean_start |=> (s.words_left == $past(words_per_slave[s.cur]));
    endproperty
    a_words_loaded: assert property (p_words_loaded) else $error("Word count not taken for slave.");
endmodule // sms_master

// >>> design/sms_pkg.sv
/*
 * Shared constants and types of the multi-slave serial master.
 * Assumes a single 250 MHz core clock and a synchronous active-high reset.
 */
package sms_pkg;
    localparam int SMS_SLAVES        = 2;
    localparam int SMS_WORD_MAX      = 16;
    localparam int SMS_BITS_W        = 5;
    localparam int SMS_WPS_W         = 6;
    localparam int SMS_FIFO_WIDTH    = 16;
    localparam int SMS_FIFO_DEPTH    = 32;
    localparam int SMS_RX_DEPTH      = 32;
    localparam int SMS_DIV_W         = 16;
    localparam int SMS_EDGE_W        = 6;
    localparam int SMS_CLK_PERIOD_NS = 4;
    localparam logic [15:0] SMS_SR_RESET = 16'h0000;
    localparam logic [4:0]  SMS_BITS_MIN = 5'h01;
    localparam logic [4:0]  SMS_BITS_MAX = 5'h10;

    typedef enum logic [1:0] {
        SMS_IDLE  = 2'b00,
        SMS_LOAD  = 2'b01,
        SMS_SHIFT = 2'b10,
        SMS_END   = 2'b11
    } sms_state_t;
endpackage

// >>> design/sms_word_if.sv
/*
 * Valid/ready word carrier between the master and its FIFO and receive memory.
 * Assumes both ends run on the same clock.
 */
interface sms_word_if #(
    parameter int W = 16
);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input  ready);
    modport snk (input  valid, input  data, output ready);
endinterface

// >>> design/sms_fifo.sv
/*
 * Transmit word FIFO with valid and ready on both sides.
 * Assumes DEPTH is a power of two; full and empty come from registers.
 */
module sms_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 32
) (
    input  wire logic          clk,
    input  wire logic          reset,
    input  wire logic          in_valid,
    input  wire logic [W-1:0]  in_data,
    output logic               in_ready,
    sms_word_if.src            out
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0]           wp;
        logic [PW-1:0]           rp;
        logic [CW-1:0]           count;
        logic                    not_full;
        logic                    not_empty;
    } sms_fifo_state_t;

    sms_fifo_state_t s;
    sms_fifo_state_t next_s;
    logic            push;
    logic            pop;

    always_comb begin
        next_s = s;
        push   = in_valid && s.not_full;
        pop    = s.not_empty && out.ready;
        if (push) begin
            next_s.mem[s.wp] = in_data;
            next_s.wp        = s.wp + 1'b1;
        end
        if (pop) begin
            next_s.rp = s.rp + 1'b1;
        end
        next_s.count     = s.count + CW'(push) - CW'(pop);
        next_s.not_full  = (next_s.count != CW'(DEPTH));
        next_s.not_empty = (next_s.count != '0);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s          <= '0;
            s.not_full <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign in_ready  = s.not_full;
    assign out.valid = s.not_empty;
    assign out.data  = s.mem[s.rp];

    property p_fifo_count;
        @(posedge clk) disable iff (reset)
        (push && !pop) |=> (s.count == $past(s.count) + 1'b1);
    endproperty
    a_fifo_count: assert property (p_fifo_count) else $error("FIFO count did not follow a push.");
endmodule // sms_fifo

// >>> design/sms_rx_mem.sv
/*
 * Receive vector memory: one word per position of the concatenated vector.
 * Assumes write words carry the address above the data bits; read data is registered.
 */
module sms_rx_mem #(
    parameter int W     = 16,
    parameter int DEPTH = 32
) (
    input  wire logic                     clk,
    input  wire logic                     reset,
    sms_word_if.snk                       wr,
    input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic      [W-1:0]             rd_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [W-1:0]            rd;
    } sms_mem_state_t;

    sms_mem_state_t s;
    sms_mem_state_t next_s;

    always_comb begin
        next_s    = s;
        next_s.rd = s.mem[rd_addr];
        if (wr.valid) begin
            next_s.mem[wr.data[W+AW-1:W]] = wr.data[W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign wr.ready = 1'b1;
    assign rd_data  = s.rd;
endmodule // sms_rx_mem

// >>> testbench/sms_slave_model.sv
/*
 * Behavioural serial slave: answers with base plus the number of words it has heard, and records them.
 * Assumes mode inputs and word length stay stable while its select is low.
 */
module sms_slave_model (
    input  wire logic        shift_clock,
    input  wire logic        sel_n,
    input  wire logic        cpol,
    input  wire logic        cpha,
    input  wire logic [4:0]  bits,
    input  wire logic [15:0] base,
    input  wire logic        si,
    output logic             so
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] rx_w [0:63];
    logic [15:0] sh;
    logic [15:0] cur;
    int          rx_n = 0;
    int          bitc = 0;
    initial so = 1'b0;
    // The word on the line is always the one after those already heard, so no prefetch can go astray.
    task automatic drive();
        cur = base + 16'(rx_n);
        so = cur[int'(bits) - 1 - bitc];
    endtask
    always @(negedge sel_n) begin
        bitc = 0;
        sh = 16'h0000;
        if (cpha) drive();
    end
    // A released line must not keep its last level, or a late sample would still look right.
    always @(posedge sel_n) so = ~so;
    always @(shift_clock) begin
        if (!sel_n) begin
            if ((shift_clock != cpol) == cpha) begin
                sh = {sh[14:0], si};
                bitc = bitc + 1;
                if (bitc == int'(bits)) begin
                    rx_w[rx_n] = sh;
                    rx_n = rx_n + 1;
                    bitc = 0;
                    sh = 16'h0000;
                end
            end else begin
                drive();
            end
        end
    end
endmodule // sms_slave_model

// >>> testbench/sms_master_test.sv
/*
 * Self-checking bench of the multi-slave serial master with two slave models.
 * Assumes the design's own assertions watch timing; this bench judges data, counts and flags.
 */
module sms_master_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic            clk = 1'b0;
    logic            reset = 1'b1;
    logic            step = 1'b0;
    logic            cpol = 1'b0;
    logic            cpha = 1'b0;
    logic [4:0]      bits_per_word = 5'h08;
    logic [15:0]     clk_half = 16'h0010;
    logic [1:0][5:0] wps = '0;
    logic            tx_valid = 1'b0;
    logic [15:0]     tx_data = 16'h0000;
    logic            tx_ready;
    logic [4:0]      rx_rd_addr = 5'h00;
    logic [15:0]     rx_rd_data;
    logic            shift_clock;
    logic            mosi;
    logic            miso;
    logic [1:0]      slave_select_n;
    logic            busy;
    logic            valid;
    logic            overrun;
    logic            so0;
    logic            so1;
    logic [15:0]     rd;
    logic [15:0]     txq [$];
    int              err_total = 0;
    int              total_checks = 0;
    int              edge_n = 0;
    int              word_k = 0;

    always #2 clk = ~clk;
    always @(shift_clock) edge_n++;
    assign miso = slave_select_n[0] ? so1 : so0;

    sms_master sms_master_i (.clk(clk), .reset(reset), .step(step), .cpol(cpol), .cpha(cpha),
        .bits_per_word(bits_per_word), .clk_half(clk_half), .words_per_slave(wps), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready), .rx_rd_addr(rx_rd_addr), .rx_rd_data(rx_rd_data),
        .shift_clock(shift_clock), .serial_out_to_slave(mosi), .serial_in_from_slave(miso),
        .slave_select_n(slave_select_n), .busy(busy), .valid(valid), .overrun(overrun));
    sms_slave_model slave0_i (.shift_clock(shift_clock), .sel_n(slave_select_n[0]), .cpol(cpol), .cpha(cpha),
        .bits(bits_per_word), .base(16'h3c00), .si(mosi), .so(so0));
    sms_slave_model slave1_i (.shift_clock(shift_clock), .sel_n(slave_select_n[1]), .cpol(cpol), .cpha(cpha),
        .bits(bits_per_word), .base(16'h0a57), .si(mosi), .so(so1));

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic push();
        int k;
        tx_valid <= 1'b1;
        tx_data <= 16'(word_k * 16'h1357 + 16'h2c4b);
        txq.push_back(16'(word_k * 16'h1357 + 16'h2c4b));
        word_k++;
        @(posedge clk);
        for (k = 0; k < 100 && tx_ready !== 1'b1; k++) @(posedge clk);
        if (k == 100) begin
            err_total++;
            tally_and_finish();
        end
    endtask

    task automatic pulse_step();
        step <= 1'b1;
        @(posedge clk);
        step <= 1'b0;
        #1;
    endtask

    task automatic wait_idle();
        int k;
        for (k = 0; k < 40000 && busy !== 1'b0; k++) @(posedge clk);
        if (busy !== 1'b0) begin
            err_total++;
            tally_and_finish();
        end
        @(posedge clk);
    endtask

    task automatic read_rx(input int a);
        @(posedge clk);
        rx_rd_addr <= 5'(a);
        repeat (2) @(posedge clk);
        #1 rd = rx_rd_data;
    endtask

    task automatic run_step(input int s);
        int          n;
        int          j;
        int          w;
        int          ab;
        logic [15:0] m;
        logic [15:0] b;
        m = 16'hffff >> (16 - int'(bits_per_word));
        n = s ? slave1_i.rx_n : slave0_i.rx_n;
        b = s ? 16'h0a57 : 16'h3c00;
        w = int'(wps[s]);
        ab = s ? int'(wps[0]) : 0;
        @(posedge clk);
        edge_n = 0;
        pulse_step();
        check(16'(slave_select_n), s ? 16'h0001 : 16'h0002);
        wait_idle();
        check(16'(edge_n), 16'(2 * int'(bits_per_word) * w));
        check(16'(slave_select_n), 16'h0003);
        check(16'(shift_clock), 16'(cpol));
        for (j = 0; j < w; j++) begin
            check(s ? slave1_i.rx_w[n + j] : slave0_i.rx_w[n + j], txq.pop_front() & m);
            read_rx(ab + j);
            check(rd, (b + 16'(n + j)) & m);
        end
    endtask

    task automatic round(input logic pol, input logic pha, input int nb, input int w0, input int w1,
                         input logic v0);
        int k;
        @(posedge clk);
        cpol <= pol;
        cpha <= pha;
        bits_per_word <= 5'(nb);
        wps <= {6'(w1), 6'(w0)};
        for (k = 0; k < w0 + w1; k++) push();
        tx_valid <= 1'b0;
        repeat (4) @(posedge clk);
        check(16'(shift_clock), 16'(pol));
        run_step(0);
        check(16'(valid), 16'(v0));
        run_step(1);
        check(16'(valid), 16'h0001);
    endtask

    task automatic fill_fifo();
        int k;
        @(posedge clk);
        bits_per_word <= 5'h04;
        wps <= {6'h10, 6'h10};
        for (k = 0; k < 32; k++) push();
        tx_data <= 16'hdead;
        @(posedge clk);
        tx_valid <= 1'b0;
        #1 check(16'(tx_ready), 16'h0000);
        run_step(0);
        check(16'(tx_ready), 16'h0001);
        run_step(1);
    endtask

    task automatic overrun_case();
        int k;
        @(posedge clk);
        wps <= {6'h02, 6'h02};
        for (k = 0; k < 4; k++) push();
        tx_valid <= 1'b0;
        @(posedge clk);
        pulse_step();
        repeat (20) @(posedge clk);
        pulse_step();
        check(16'(overrun), 16'h0001);
        check(16'(slave_select_n), 16'h0002);
        wait_idle();
        check(16'(overrun), 16'h0001);
        void'(txq.pop_front());
        void'(txq.pop_front());
        run_step(1);
        check(16'(overrun), 16'h0000);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        check(16'(slave_select_n), 16'h0003);
        check({13'h0000, busy, valid, overrun}, 16'h0000);
        check({14'h0000, tx_ready, shift_clock}, 16'h0002);
        read_rx(0);
        check(rd, 16'h0000);
        round(1'b0, 1'b0, 16, 3, 2, 1'b0);
        round(1'b0, 1'b1, 1, 2, 3, 1'b1);
        round(1'b1, 1'b0, 8, 1, 1, 1'b1);
        round(1'b1, 1'b1, 5, 4, 1, 1'b1);
        round(1'b0, 1'b0, 8, 2, 0, 1'b1);
        fill_fifo();
        overrun_case();
        tally_and_finish();
    end
endmodule // sms_master_test
